// ==== rtl/autoneg_mgmt_registers.sv ====
// How it works
// - Control, status, advertisement, partner, expansion registers present.
// - Page transmit register at address seven.
// - Control bit twelve enables negotiation.
// - Enabled: ignore manual speed and duplex.
// - Restart bit reads one until initiated.
// - Writing one with bit twelve also one restarts; self-clears; zero ignored.
// - Complete bit zero when disabled or incapable.
// - Complete bit set on successful negotiation.
// - Remote fault sticky until status read.
// - Advertisement resets to selector, ack zero, abilities.
// - Partner register read-only, mirrors received codeword.
// - Expansion register read-only, writes ignored.
// - Expansion bit zero: partner can negotiate.
// - Page received bit set, cleared on read.
// - Expansion bit two: local extra pages.
// - Expansion bit three: partner extra pages.
// - Parallel detect fault set, cleared on read.
// - Storage location and location-able bits provided.
// - Page transmit register resets to 2001.
// - Page transmit write sets staged flag.
// - Local ability vector driven as logic.
// - Extra page flags driven as logic.
// - Received remote fault sets status bit four.
module autoneg_mgmt_registers #(
    parameter logic [4:0] ABILITY = autoneg_pkg::ABILITY_DEFAULT,
    parameter logic [4:0] SELECTOR = autoneg_pkg::SELECTOR_DEFAULT,
    parameter logic LOCAL_NP_ABLE = 1'b1,
    parameter logic NP_LOC_ABLE = 1'b0,
    parameter logic NP_LOC = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic an_capable,
    input wire logic link_up,
    input wire logic neg_speed_sel,
    input wire logic neg_duplex_sel,
    input wire logic an_complete_evt,
    input wire logic restart_started,
    input wire logic rx_page_valid,
    input wire logic rx_page_base,
    input wire logic [15:0] rx_page,
    input wire logic partner_an_able,
    input wire logic pd_timer_expired,
    input wire logic [2:0] link_ready,
    input wire logic tx_page_sent,
    output logic autoneg_enable,
    output logic restart_req,
    output logic link_speed_sel,
    output logic link_duplex_sel,
    output logic [15:0] local_ability_vector,
    output logic [15:0] tx_page_word,
    output logic tx_page_staged_flag,
    output logic local_extra_pages_capable,
    output logic partner_extra_pages_capable,
    output logic more_pages_follow_bit
);

    // Advertisement power-on value, built from straps.
    localparam autoneg_pkg::reg_word_t ADVERT_RESET =
        autoneg_pkg::tech_field(ABILITY) | {11'h000, SELECTOR} |
        {LOCAL_NP_ABLE, 15'h0000};

    autoneg_pkg::reg_word_t control_q;
    autoneg_pkg::reg_word_t control_d;
    autoneg_pkg::reg_word_t advert_q;
    autoneg_pkg::reg_word_t partner_q;
    autoneg_pkg::reg_word_t page_tx_q;
    autoneg_pkg::reg_word_t rdata_q;
    autoneg_pkg::reg_word_t read_mux;
    autoneg_pkg::reg_word_t status_word;
    autoneg_pkg::reg_word_t expansion_word;
    autoneg_pkg::restart_state_t state_q;
    autoneg_pkg::restart_state_t state_d;
    logic rvalid_q;
    logic complete_q;
    logic complete_d;
    logic staged_q;
    logic partner_np_q;
    logic partner_able_q;

    sticky_if flags_bus ();

    sticky_flags u_flags (
        .clk(clk),
        .rst(rst),
        .bus(flags_bus)
    );

    // Address decode.
    wire hit_control = (mgmt_addr == autoneg_pkg::ADDR_CONTROL);
    wire hit_status = (mgmt_addr == autoneg_pkg::ADDR_STATUS);
    wire hit_advert = (mgmt_addr == autoneg_pkg::ADDR_ADVERT);
    wire hit_partner = (mgmt_addr == autoneg_pkg::ADDR_PARTNER);
    wire hit_expansion = (mgmt_addr == autoneg_pkg::ADDR_EXPANSION);
    wire hit_page_tx = (mgmt_addr == autoneg_pkg::ADDR_PAGE_TX) && LOCAL_NP_ABLE;

    wire wr_control = mgmt_wr && hit_control;
    wire wr_advert = mgmt_wr && hit_advert;
    wire wr_page_tx = mgmt_wr && hit_page_tx;
    wire rd_status = mgmt_rd && hit_status;
    wire rd_expansion = mgmt_rd && hit_expansion;

    wire enable_now = control_q[autoneg_pkg::CTL_ENABLE_BIT];
    wire enable_next = control_d[autoneg_pkg::CTL_ENABLE_BIT];
    wire restart_wr = wr_control && mgmt_wdata[autoneg_pkg::CTL_RESTART_BIT] &&
        mgmt_wdata[autoneg_pkg::CTL_ENABLE_BIT];
    wire negotiation_live = enable_now && an_capable;

    // Control register keeps all written bits; the restart bit lives in the state machine.
    always_comb begin
        control_d = control_q;
        if (wr_control) begin
            control_d = mgmt_wdata;
        end
        control_d[autoneg_pkg::CTL_RESTART_BIT] = 1'b0;
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            autoneg_pkg::RS_IDLE: begin
                if (restart_wr) begin
                    state_d = autoneg_pkg::RS_PENDING;
                end
            end
            autoneg_pkg::RS_PENDING: begin
                if (restart_started && !restart_wr) begin
                    state_d = autoneg_pkg::RS_RUNNING;
                end
            end
            autoneg_pkg::RS_RUNNING: begin
                if (restart_wr) begin
                    state_d = autoneg_pkg::RS_PENDING;
                end else if (an_complete_evt) begin
                    state_d = autoneg_pkg::RS_DONE;
                end
            end
            autoneg_pkg::RS_DONE: begin
                if (restart_wr) begin
                    state_d = autoneg_pkg::RS_PENDING;
                end
            end
            default: begin
                state_d = autoneg_pkg::RS_IDLE;
            end
        endcase
        // A disabled function has nothing to restart.
        if (!enable_next) begin
            state_d = autoneg_pkg::RS_IDLE;
        end
    end

    wire restart_bit = (state_q == autoneg_pkg::RS_PENDING);

    always_comb begin
        complete_d = complete_q;
        if (restart_wr) begin
            complete_d = 1'b0;
        end
        if (an_complete_evt) begin
            complete_d = 1'b1;
        end
        if (!negotiation_live || !enable_next) begin
            complete_d = 1'b0;
        end
    end

    wire rfault_evt = rx_page_valid && rx_page_base && rx_page[autoneg_pkg::CW_RF_BIT];
    wire pd_fault_evt = pd_timer_expired &&
        (autoneg_pkg::ready_count(link_ready) != autoneg_pkg::READY_ONE);

    // Clears take effect at the edge that captures the read data.
    always_comb begin
        flags_bus.set_evt = '0;
        flags_bus.clr = '0;
        flags_bus.set_evt[autoneg_pkg::FLAG_RFAULT] = rfault_evt;
        flags_bus.set_evt[autoneg_pkg::FLAG_PAGE_RX] = rx_page_valid;
        flags_bus.set_evt[autoneg_pkg::FLAG_PD_FAULT] = pd_fault_evt;
        flags_bus.clr[autoneg_pkg::FLAG_RFAULT] = rd_status;
        flags_bus.clr[autoneg_pkg::FLAG_PAGE_RX] = rd_expansion;
        flags_bus.clr[autoneg_pkg::FLAG_PD_FAULT] = rd_expansion;
    end

    // Status register view.
    always_comb begin
        status_word = autoneg_pkg::WORD_ZERO;
        status_word[autoneg_pkg::STS_ABIL_HI:autoneg_pkg::STS_ABIL_LO] = ABILITY;
        status_word[autoneg_pkg::STS_COMPLETE_BIT] = complete_q && negotiation_live;
        status_word[autoneg_pkg::STS_RFAULT_BIT] = flags_bus.flags[autoneg_pkg::FLAG_RFAULT];
        status_word[autoneg_pkg::STS_AN_ABLE_BIT] = an_capable;
        status_word[autoneg_pkg::STS_LINK_BIT] = link_up;
    end

    // Expansion register view.
    always_comb begin
        expansion_word = autoneg_pkg::WORD_ZERO;
        expansion_word[autoneg_pkg::EXP_PARTNER_ABLE] = partner_able_q;
        expansion_word[autoneg_pkg::EXP_PAGE_RX] = flags_bus.flags[autoneg_pkg::FLAG_PAGE_RX];
        expansion_word[autoneg_pkg::EXP_LOCAL_NP] = LOCAL_NP_ABLE;
        expansion_word[autoneg_pkg::EXP_PARTNER_NP] = partner_np_q;
        expansion_word[autoneg_pkg::EXP_PD_FAULT] = flags_bus.flags[autoneg_pkg::FLAG_PD_FAULT];
        expansion_word[autoneg_pkg::EXP_NP_LOC] = NP_LOC && NP_LOC_ABLE;
        expansion_word[autoneg_pkg::EXP_NP_LOC_ABLE] = NP_LOC_ABLE;
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        read_mux = autoneg_pkg::WORD_ZERO;
        if (hit_control) begin
            read_mux = control_q;
            read_mux[autoneg_pkg::CTL_RESTART_BIT] = restart_bit;
        end else if (hit_status) begin
            read_mux = status_word;
        end else if (hit_advert) begin
            read_mux = advert_q;
        end else if (hit_partner) begin
            read_mux = partner_q;
        end else if (hit_expansion) begin
            read_mux = expansion_word;
        end else if (hit_page_tx) begin
            read_mux = page_tx_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_q <= autoneg_pkg::CONTROL_RESET;
            state_q <= autoneg_pkg::RS_IDLE;
            complete_q <= 1'b0;
        end else begin
            control_q <= control_d;
            state_q <= state_d;
            complete_q <= complete_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            advert_q <= ADVERT_RESET;
        end else if (wr_advert) begin
            advert_q <= mgmt_wdata;
        end
    end

    // Mirror of received codeword; no write path exists.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partner_q <= autoneg_pkg::WORD_ZERO;
        end else if (rx_page_valid) begin
            partner_q <= rx_page;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partner_np_q <= 1'b0;
            partner_able_q <= 1'b0;
        end else begin
            if (rx_page_valid && rx_page_base) begin
                partner_np_q <= rx_page[autoneg_pkg::CW_NP_BIT];
            end
            partner_able_q <= partner_an_able;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_tx_q <= autoneg_pkg::PAGE_TX_RESET;
        end else if (wr_page_tx) begin
            page_tx_q <= mgmt_wdata;
        end
    end

    // Write stages the page; a write beats a send in the same cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            staged_q <= 1'b0;
        end else if (wr_page_tx) begin
            staged_q <= 1'b1;
        end else if (tx_page_sent) begin
            staged_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= autoneg_pkg::WORD_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= mgmt_rd;
            if (mgmt_rd) begin
                rdata_q <= read_mux;
            end
        end
    end

    assign mgmt_rdata = rdata_q;
    assign mgmt_rvalid = rvalid_q;
    assign autoneg_enable = enable_now;
    assign restart_req = restart_bit;

    assign link_speed_sel = enable_now ? neg_speed_sel : control_q[autoneg_pkg::CTL_SPEED_BIT];
    assign link_duplex_sel = enable_now ? neg_duplex_sel : control_q[autoneg_pkg::CTL_DUPLEX_BIT];

    assign local_ability_vector = advert_q;
    assign tx_page_word = page_tx_q;

    assign tx_page_staged_flag = staged_q;
    assign local_extra_pages_capable = LOCAL_NP_ABLE;
    assign partner_extra_pages_capable = partner_np_q;
    assign more_pages_follow_bit = LOCAL_NP_ABLE &&
        (staged_q ? page_tx_q[autoneg_pkg::CW_NP_BIT] : advert_q[autoneg_pkg::CW_NP_BIT]);

endmodule : autoneg_mgmt_registers

// ==== rtl/autoneg_pkg.sv ====
package autoneg_pkg;

    typedef logic [15:0] reg_word_t;
    typedef logic [4:0] mgmt_addr_t;

    // Management register addresses.
    localparam mgmt_addr_t ADDR_CONTROL = 5'h00;
    localparam mgmt_addr_t ADDR_STATUS = 5'h01;
    localparam mgmt_addr_t ADDR_ADVERT = 5'h04;
    localparam mgmt_addr_t ADDR_PARTNER = 5'h05;
    localparam mgmt_addr_t ADDR_EXPANSION = 5'h06;
    localparam mgmt_addr_t ADDR_PAGE_TX = 5'h07;

    // Control register fields.
    localparam int CTL_SPEED_BIT = 13;
    localparam int CTL_ENABLE_BIT = 12;
    localparam int CTL_RESTART_BIT = 9;
    localparam int CTL_DUPLEX_BIT = 8;

    // Status register fields.
    localparam int STS_ABIL_HI = 15;
    localparam int STS_ABIL_LO = 11;
    localparam int STS_COMPLETE_BIT = 5;
    localparam int STS_RFAULT_BIT = 4;
    localparam int STS_AN_ABLE_BIT = 3;
    localparam int STS_LINK_BIT = 2;

    // Advertisement and received codeword fields.
    localparam int CW_NP_BIT = 15;
    localparam int CW_ACK_BIT = 14;
    localparam int CW_RF_BIT = 13;
    localparam int ADV_SEL_HI = 4;
    localparam int ADV_SEL_LO = 0;
    localparam int ADV_TECH_HI = 9;
    localparam int ADV_TECH_LO = 5;

    // Expansion register fields.
    localparam int EXP_PARTNER_ABLE = 0;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LOCAL_NP = 2;
    localparam int EXP_PARTNER_NP = 3;
    localparam int EXP_PD_FAULT = 4;
    localparam int EXP_NP_LOC = 5;
    localparam int EXP_NP_LOC_ABLE = 6;

    // Reset values.
    localparam reg_word_t CONTROL_RESET = 16'h1000;
    localparam reg_word_t PAGE_TX_RESET = 16'h2001;
    localparam reg_word_t WORD_ZERO = 16'h0000;
    localparam logic [4:0] SELECTOR_DEFAULT = 5'h01;
    localparam logic [4:0] ABILITY_DEFAULT = 5'h1F;

    // Clear-on-read flag slots.
    localparam int FLAG_RFAULT = 0;
    localparam int FLAG_PAGE_RX = 1;
    localparam int FLAG_PD_FAULT = 2;
    localparam int FLAG_N = 3;

    // Link-ready reporters: legacy pulse detector and two media attachments.
    localparam int READY_N = 3;
    localparam logic [1:0] READY_ONE = 2'h1;

    typedef enum logic [3:0] {
        RS_IDLE = 4'h1,
        RS_PENDING = 4'h2,
        RS_RUNNING = 4'h4,
        RS_DONE = 4'h8
    } restart_state_t;

    // Status ability bits 15..11 map onto advertisement bits 9..5.
    function automatic reg_word_t tech_field(input logic [4:0] abil);
        reg_word_t w;
        w = WORD_ZERO;
        w[ADV_TECH_HI:ADV_TECH_LO] = abil;
        return w;
    endfunction : tech_field

    function automatic logic [1:0] ready_count(input logic [READY_N-1:0] r);
        logic [1:0] c;
        c = 2'h0;
        for (int i = 0; i < READY_N; i++) begin
            c = c + {1'b0, r[i]};
        end
        return c;
    endfunction : ready_count

endpackage : autoneg_pkg

// ==== rtl/sticky_if.sv ====
interface sticky_if;
    logic [autoneg_pkg::FLAG_N-1:0] set_evt;
    logic [autoneg_pkg::FLAG_N-1:0] clr;
    logic [autoneg_pkg::FLAG_N-1:0] flags;

    modport owner (input set_evt, input clr, output flags);
    modport user (output set_evt, output clr, input flags);
endinterface : sticky_if

// ==== rtl/sticky_flags.sv ====
module sticky_flags (
    input wire logic clk,
    input wire logic rst,
    sticky_if.owner bus
);
    logic [autoneg_pkg::FLAG_N-1:0] flags_q;
    logic [autoneg_pkg::FLAG_N-1:0] flags_d;

    // A set in the cycle of the clearing read wins, so no event is lost.
    assign flags_d = bus.set_evt | (flags_q & ~bus.clr);
    assign bus.flags = flags_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule : sticky_flags

// ==== tb/autoneg_chk.sv ====
module autoneg_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire logic an_capable,
    input wire logic neg_speed_sel,
    input wire logic neg_duplex_sel,
    input wire logic restart_started,
    input wire logic autoneg_enable,
    input wire logic restart_req,
    input wire logic link_speed_sel,
    input wire logic link_duplex_sel,
    input wire logic [15:0] local_ability_vector,
    input wire logic [15:0] tx_page_word,
    input wire logic tx_page_staged_flag,
    input wire logic local_extra_pages_capable,
    input wire logic more_pages_follow_bit
);
    timeunit 1ns;
    timeprecision 100ps;

    wire logic ctl_wr = mgmt_wr && mgmt_addr == autoneg_pkg::ADDR_CONTROL;
    wire logic sts_rd = mgmt_rd && mgmt_addr == autoneg_pkg::ADDR_STATUS;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_read_answer: assert property (mgmt_rd |=> mgmt_rvalid)
        else $error("read not answered next cycle");
    chk_no_stray_answer: assert property (!mgmt_rd |=> !mgmt_rvalid)
        else $error("answer without read");
    chk_config_negotiated: assert property (
        autoneg_enable |-> link_speed_sel == neg_speed_sel && link_duplex_sel == neg_duplex_sel)
        else $error("manual config used while negotiating");
    chk_restart_set: assert property (
        ctl_wr && mgmt_wdata[9] && mgmt_wdata[12] && !restart_started |=> restart_req)
        else $error("restart write not taken");
    chk_restart_holds: assert property (
        restart_req && !restart_started && (!ctl_wr || mgmt_wdata[12]) |=> restart_req)
        else $error("restart bit dropped early");
    chk_restart_clears: assert property (
        restart_req && restart_started && !ctl_wr |=> !restart_req)
        else $error("restart bit not self-cleared");
    chk_complete_forced: assert property (
        sts_rd && !(autoneg_enable && an_capable) |=> !mgmt_rdata[5])
        else $error("complete bit read one while disabled");
    chk_page_staged: assert property (
        mgmt_wr && mgmt_addr == autoneg_pkg::ADDR_PAGE_TX
        |=> tx_page_staged_flag && tx_page_word == $past(mgmt_wdata))
        else $error("page write did not stage");
    chk_advert_write: assert property (
        mgmt_wr && mgmt_addr == autoneg_pkg::ADDR_ADVERT |=> local_ability_vector == $past(mgmt_wdata))
        else $error("advertisement write lost");
    chk_more_pages_bit: assert property (
        more_pages_follow_bit == (local_extra_pages_capable &&
        (tx_page_staged_flag ? tx_page_word[15] : local_ability_vector[15])))
        else $error("more pages bit wrong");
endmodule : autoneg_chk

bind autoneg_mgmt_registers autoneg_chk u_chk (.clk, .rst, .mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd,
    .mgmt_rdata, .mgmt_rvalid, .an_capable, .neg_speed_sel, .neg_duplex_sel, .restart_started,
    .autoneg_enable, .restart_req, .link_speed_sel, .link_duplex_sel, .local_ability_vector,
    .tx_page_word, .tx_page_staged_flag, .local_extra_pages_capable, .more_pages_follow_bit);

// ==== tb/mgmt_station.sv ====
module mgmt_station (
    input wire logic clk,
    output logic [4:0] mgmt_addr,
    output logic [15:0] mgmt_wdata,
    output logic mgmt_wr,
    output logic mgmt_rd,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        mgmt_addr = 5'h1F;
        mgmt_wdata = 16'hFFFF;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
    end

    // Released lines show the inverse, so a stale value never passes for a fresh one.
    // Whole 16-bit words.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr <= 1'b1;
        @(posedge clk);
        mgmt_wr <= 1'b0;
        mgmt_addr <= ~a;
        mgmt_wdata <= ~d;
        #1;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk);
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge clk);
        mgmt_rd <= 1'b0;
        mgmt_addr <= ~a;
        #1;
        ok = mgmt_rvalid;
        d = mgmt_rdata;
    endtask : rd
endmodule : mgmt_station

// ==== tb/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, mgmt_wr, mgmt_rd, mgmt_rvalid, an_capable, link_up, neg_speed_sel, neg_duplex_sel;
    logic rx_page_base, partner_an_able, autoneg_enable, restart_req, link_speed_sel, link_duplex_sel;
    logic tx_page_staged_flag, local_extra_pages_capable, partner_extra_pages_capable, more_pages_follow_bit;
    logic [4:0] mgmt_addr, evt;
    logic [2:0] link_ready;
    logic [15:0] mgmt_wdata, mgmt_rdata, rx_page, local_ability_vector, tx_page_word;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    mgmt_station u_sta (.clk(clk), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    autoneg_mgmt_registers u_dut (.clk(clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .an_capable(an_capable), .link_up(link_up), .neg_speed_sel(neg_speed_sel),
        .neg_duplex_sel(neg_duplex_sel), .an_complete_evt(evt[0]), .restart_started(evt[1]),
        .rx_page_valid(evt[2]), .rx_page_base(rx_page_base), .rx_page(rx_page),
        .partner_an_able(partner_an_able), .pd_timer_expired(evt[3]), .link_ready(link_ready),
        .tx_page_sent(evt[4]), .autoneg_enable(autoneg_enable), .restart_req(restart_req),
        .link_speed_sel(link_speed_sel), .link_duplex_sel(link_duplex_sel),
        .local_ability_vector(local_ability_vector), .tx_page_word(tx_page_word),
        .tx_page_staged_flag(tx_page_staged_flag), .local_extra_pages_capable(local_extra_pages_capable),
        .partner_extra_pages_capable(partner_extra_pages_capable),
        .more_pages_follow_bit(more_pages_follow_bit));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // The whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic fl(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : fl

    task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        u_sta.rd(a, d, ok);
        fl(ok, 1'b1);
        chk(d & m, e);
    endtask : rc

    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 5'h00;
        #1;
    endtask : pulse

    task automatic t_reset();
        rc(autoneg_pkg::ADDR_CONTROL, 16'hFFFF, 16'h1000);
        rc(autoneg_pkg::ADDR_STATUS, 16'hF83C, {autoneg_pkg::ABILITY_DEFAULT, 11'h008});
        rc(autoneg_pkg::ADDR_ADVERT, 16'hFFFF, 16'h83E1);
        rc(autoneg_pkg::ADDR_PARTNER, 16'hFFFF, 16'h0000);
        rc(autoneg_pkg::ADDR_EXPANSION, 16'hFFFF, 16'h0004);
        rc(autoneg_pkg::ADDR_PAGE_TX, 16'hFFFF, 16'h2001);
        rc(5'h02, 16'hFFFF, 16'h0000);
        chk(local_ability_vector, 16'h83E1);
        fl(local_extra_pages_capable, 1'b1);
    endtask : t_reset

    task automatic t_restart();
        u_sta.wr(autoneg_pkg::ADDR_CONTROL, 16'h1200);
        fl(restart_req, 1'b1);
        rc(autoneg_pkg::ADDR_CONTROL, 16'hFFFF, 16'h1200);
        u_sta.wr(autoneg_pkg::ADDR_CONTROL, 16'h1000);
        rc(autoneg_pkg::ADDR_CONTROL, 16'hFFFF, 16'h1200);
        pulse(5'h02);
        fl(restart_req, 1'b0);
        rc(autoneg_pkg::ADDR_CONTROL, 16'hFFFF, 16'h1000);
    endtask : t_restart

    task automatic t_config();
        pulse(5'h01);
        rc(autoneg_pkg::ADDR_STATUS, 16'h0020, 16'h0020);
        fl(link_speed_sel, 1'b0);
        u_sta.wr(autoneg_pkg::ADDR_CONTROL, 16'h2100);
        fl(autoneg_enable, 1'b0);
        chk({14'h0000, link_speed_sel, link_duplex_sel}, 16'h0003);
        rc(autoneg_pkg::ADDR_STATUS, 16'h0020, 16'h0000);
        // Manual bits set while enabled, so a leak of them would show.
        u_sta.wr(autoneg_pkg::ADDR_CONTROL, 16'h3100);
        fl(autoneg_enable, 1'b1);
        chk({14'h0000, link_speed_sel, link_duplex_sel}, 16'h0000);
        @(posedge clk);
        neg_speed_sel <= 1'b1;
        neg_duplex_sel <= 1'b1;
        #1;
        chk({14'h0000, link_speed_sel, link_duplex_sel}, 16'h0003);
        pulse(5'h01);
        @(posedge clk);
        an_capable <= 1'b0;
        link_up <= 1'b1;
        rc(autoneg_pkg::ADDR_STATUS, 16'h002C, 16'h0004);
        @(posedge clk);
        an_capable <= 1'b1;
    endtask : t_config

    task automatic t_fault();
        @(posedge clk);
        rx_page <= 16'hE5A1;
        rx_page_base <= 1'b1;
        partner_an_able <= 1'b1;
        pulse(5'h04);
        rc(autoneg_pkg::ADDR_PARTNER, 16'hFFFF, 16'hE5A1);
        u_sta.wr(autoneg_pkg::ADDR_PARTNER, 16'h1234);
        rc(autoneg_pkg::ADDR_PARTNER, 16'hFFFF, 16'hE5A1);
        fl(partner_extra_pages_capable, 1'b1);
        rc(autoneg_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
        rc(autoneg_pkg::ADDR_STATUS, 16'h0010, 16'h0000);
        u_sta.wr(autoneg_pkg::ADDR_EXPANSION, 16'hFFFF);
        rc(autoneg_pkg::ADDR_EXPANSION, 16'hFFFF, 16'h000F);
        rc(autoneg_pkg::ADDR_EXPANSION, 16'hFFFF, 16'h000D);
    endtask : t_fault

    task automatic t_pdfault();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            link_ready <= i[2:0];
            pulse(5'h08);
            rc(autoneg_pkg::ADDR_EXPANSION, 16'h0010, ($countones(i[2:0]) != 1) ? 16'h0010 : 16'h0000);
        end
    endtask : t_pdfault

    task automatic t_page();
        u_sta.wr(autoneg_pkg::ADDR_ADVERT, 16'h01E1);
        chk(local_ability_vector, 16'h01E1);
        fl(more_pages_follow_bit, 1'b0);
        u_sta.wr(autoneg_pkg::ADDR_PAGE_TX, 16'h8123);
        fl(tx_page_staged_flag, 1'b1);
        fl(more_pages_follow_bit, 1'b1);
        pulse(5'h10);
        fl(tx_page_staged_flag, 1'b0);
        rc(autoneg_pkg::ADDR_PAGE_TX, 16'hFFFF, 16'h8123);
    endtask : t_page

    initial begin
        rst = 1'b1;
        an_capable = 1'b1;
        link_up = 1'b0;
        neg_speed_sel = 1'b0;
        neg_duplex_sel = 1'b0;
        rx_page_base = 1'b0;
        rx_page = 16'h0000;
        partner_an_able = 1'b0;
        link_ready = 3'h0;
        evt = 5'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_restart();
        t_config();
        t_fault();
        t_pdfault();
        t_page();
        close_out();
    end
endmodule : testbench
